/* hw/ptc_control.sv */
`timescale 1ns/1ps
// Function
// R1 - base registers reachable only on page four
// R2 - top three control bits read zero
// R3 - three-bit trigger select, reset zero
// R4 - disable strobe disables trigger, reads zero
// R5 - disabled trigger keeps driving its pin
// R6 - enable strobe enables trigger, reads zero
// R7 - readback start streams fields via data port
// R8 - program start disables, then writes load fields
// R9 - load ends on all fields or enable
// R10 - sample strobe captures clock time, reads zero
// R11 - one word per access, zero past end
// R12 - zero writes harmless, clear on own clock
module ptc_control
    import ptc_pkg::*;
#(
    parameter int NUM_TRIG = ptc_pkg::PTC_NUM_TRIG,
    parameter int TRIG_WORDS = ptc_pkg::PTC_TRIG_WORDS,
    parameter int TIME_WORDS = ptc_pkg::PTC_TIME_WORDS
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // protocol clock and trigger outputs
    input wire logic [16*TIME_WORDS-1:0] i_clock_time,
    input wire logic [NUM_TRIG-1:0] i_trig_value,
    output logic [NUM_TRIG-1:0] o_trig_enabled,
    output logic [NUM_TRIG-1:0] o_trig_pin,
    output logic [16*TRIG_WORDS-1:0] o_trig_fields [NUM_TRIG]
);
    import ptc_pkg::*;

    localparam int IW = $clog2(TRIG_WORDS + TIME_WORDS + 1);

    logic [2:0] page;
    logic [2:0] trigger_select_field;
    ptc_mode_e mode;
    logic [16*TRIG_WORDS-1:0] fields [NUM_TRIG];
    logic [NUM_TRIG-1:0] enabled;
    logic [16*TIME_WORDS-1:0] sample;
    logic [31:0] readdata;
    logic ack;
    logic [IW-1:0] widx;
    logic wdone;

    // one wait state: the request is answered the edge after it is seen
    wire req = (i_avs_read || i_avs_write) && !ack;
    wire [4:0] idx = i_avs_address[6:2];
    wire lo_en = i_avs_byteenable[0];
    wire hi_en = i_avs_byteenable[1];
    wire full_en = lo_en && hi_en;
    wire on_page = (page == PTC_PAGE_TIME); // R1
    wire sel_page = (idx == PTC_IDX_PAGE_SELECT);
    wire sel_ctl = on_page && (idx == PTC_IDX_CONTROL); // R1
    wire sel_tdr = on_page && (idx == PTC_IDX_TIME_DATA); // R1
    wire wr = req && i_avs_write;
    wire rd = req && i_avs_read;
    // command bits only act when the high byte lane carries them
    wire wr_ctl = wr && sel_ctl && hi_en;
    wire cmd_dis = wr_ctl && i_avs_writedata[PTC_BIT_DISABLE]; // R12
    wire cmd_en = wr_ctl && i_avs_writedata[PTC_BIT_ENABLE]; // R12
    wire cmd_rd = wr_ctl && lo_en && i_avs_writedata[PTC_BIT_READBACK];
    wire cmd_ld = wr_ctl && lo_en && i_avs_writedata[PTC_BIT_LOAD];
    wire cmd_smp = wr_ctl && lo_en && i_avs_writedata[PTC_BIT_SAMPLE];
    wire [2:0] next_sel = i_avs_writedata[PTC_SEL_LSB +: 3];
    wire [2:0] act_sel = wr_ctl ? next_sel : trigger_select_field;
    wire tdr_step = sel_tdr && full_en && (rd || wr) && mode != PTC_IDLE; // R11
    wire restart = cmd_rd || cmd_ld || cmd_smp;
    wire [IW-1:0] nwords = (mode == PTC_CLOCK) ? IW'(TIME_WORDS) : IW'(TRIG_WORDS);
    wire in_range = widx < nwords;
    wire [15:0] trig_word = fields[trigger_select_field][16*widx[$clog2(TRIG_WORDS+1)-1:0] +: 16];
    wire [15:0] time_word = sample[16*widx +: 16];
    wire [15:0] tdr_word = !in_range ? 16'h0000 : (mode == PTC_CLOCK) ? time_word :
                           (mode == PTC_READBACK) ? trig_word : 16'h0000; // R11
    // disable, enable, readback and sample strobes never stored, so they read zero
    wire [15:0] ctl_word = {3'h0, trigger_select_field, 10'h000}; // R2 R4 R6 R10
    wire [15:0] ctl_rd = (mode == PTC_LOAD) ? (ctl_word | 16'h0040) : ctl_word; // R9
    wire [31:0] next_readdata = sel_page ? {29'h0, page} :
                                sel_ctl ? {16'h0000, ctl_rd} :
                                sel_tdr ? {16'h0000, tdr_word} : PTC_UNMAPPED_DATA;
    wire load_last = (mode == PTC_LOAD) && wr && tdr_step && (widx == IW'(TRIG_WORDS - 1));

    ptc_word_seq #(.WORDS(TRIG_WORDS + TIME_WORDS)) u_seq
    (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_restart(restart),
        .i_step(tdr_step), // R11
        .o_index(widx),
        .o_done(wdone)
    );

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            ack <= 1'b0;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= req;
            readdata <= rd ? next_readdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            page <= PTC_PAGE_RESET;
            trigger_select_field <= PTC_SEL_RESET; // R3
        end
        else
        begin
            if (wr && sel_page && lo_en)
                page <= i_avs_writedata[2:0];
            if (wr_ctl)
                trigger_select_field <= next_sel; // R3
        end
    end

    // mode ends the load on last field or enable; self-clear is local
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            mode <= PTC_IDLE;
        else if (cmd_ld)
            mode <= PTC_LOAD; // R8
        else if (cmd_rd)
            mode <= PTC_READBACK; // R7
        else if (cmd_smp)
            mode <= PTC_CLOCK; // R10
        else if (mode == PTC_LOAD && (cmd_en || load_last))
            mode <= PTC_IDLE; // R9 R12
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            enabled <= '0;
        else if (cmd_ld || cmd_dis)
            enabled[act_sel] <= 1'b0; // R4 R8
        else if (cmd_en)
            enabled[act_sel] <= 1'b1; // R6
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            sample <= '0;
        else if (cmd_smp)
            sample <= i_clock_time; // R10
    end

    // field store needs no reset; software loads before enabling
    always_ff @(posedge i_sys_clk)
    begin
        if (mode == PTC_LOAD && wr && tdr_step && in_range)
            fields[trigger_select_field][16*widx[$clog2(TRIG_WORDS+1)-1:0] +: 16] <=
                i_avs_writedata[15:0]; // R8
    end

    assign o_avs_waitrequest = req;
    assign o_avs_readdata = readdata;
    assign o_trig_enabled = enabled;
    // pin keeps the trigger value whether enabled or not
    assign o_trig_pin = i_trig_value; // R5
    assign o_trig_fields = fields;

    // multi-step behaviours are built from these sequences
    // a control read, answered the following cycle
    sequence ctl_read_s;
        (rd && sel_ctl) ##1 ack;
    endsequence

    // a page select read, answered the following cycle
    sequence page_read_s;
        (rd && sel_page) ##1 ack;
    endsequence

    // a data port read inside the open stream, answered the following cycle
    sequence stream_read_s;
        (rd && tdr_step && in_range) ##1 ack;
    endsequence

    // one data port write that lands in the trigger under load
    sequence load_word_s;
        (mode == PTC_LOAD) && wr && tdr_step;
    endsequence

    // waitrequest up for one cycle, then down
    sequence bus_answer_s;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence

    answer_one_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R12
        o_avs_waitrequest |-> bus_answer_s)
        else $error("answer not in one cycle");
    idle_nowait_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R12
        !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("waitrequest without a request");
    idle_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R11
        !ack |-> o_avs_readdata == 32'h0000_0000)
        else $error("read data outside answer cycle");

    page_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R1
        (wr && idx == PTC_IDX_CONTROL && !on_page) |=> $stable(trigger_select_field))
        else $error("control written off page");
    page_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R1
        (wr && sel_page && lo_en) |=> page == $past(i_avs_writedata[2:0]))
        else $error("page select not written");
    page_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R1
        page_read_s |-> o_avs_readdata == {29'h0, $past(page)})
        else $error("page select read wrong");
    off_page_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R1
        (rd && !on_page && !sel_page) |=> o_avs_readdata == 32'h0000_0000)
        else $error("off page read not zero");

    ctl_reserved_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R2
        ctl_read_s |-> o_avs_readdata[15:13] == 3'h0 && o_avs_readdata[9:7] == 3'h0 && !o_avs_readdata[5])
        else $error("control reserved or strobe bits read nonzero");
    ctl_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R3
        ctl_read_s |-> o_avs_readdata[PTC_SEL_LSB +: 3] == $past(trigger_select_field))
        else $error("select read back wrong");
    ctl_load_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R9
        ctl_read_s |-> o_avs_readdata[PTC_BIT_LOAD] == ($past(mode) == PTC_LOAD))
        else $error("load flag read back wrong");
    sel_reset_a: assert property (@(posedge i_sys_clk) // R3
        !i_rstn |=> trigger_select_field == PTC_SEL_RESET)
        else $error("select not reset");
    sel_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R3
        wr_ctl |=> trigger_select_field == $past(next_sel))
        else $error("select not written");
    sel_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R3
        !wr_ctl |=> $stable(trigger_select_field))
        else $error("select changed without a write");

    dis_effect_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R4
        (cmd_dis && !cmd_ld) |=> !enabled[$past(act_sel)])
        else $error("disable did not act");
    en_effect_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R6
        (cmd_en && !cmd_dis && !cmd_ld) |=> enabled[$past(act_sel)])
        else $error("enable did not act");
    en_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R12
        !(cmd_dis || cmd_en || cmd_ld) |=> $stable(enabled))
        else $error("enable state changed without a command");
    pin_follow_a: assert property (@(posedge i_sys_clk) o_trig_pin == i_trig_value) // R5
        else $error("pin not driven by trigger");

    load_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R8
        cmd_ld |=> mode == PTC_LOAD && !enabled[$past(act_sel)])
        else $error("load start wrong");
    field_store_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R8
        (load_word_s ##0 in_range) |=>
            16'(o_trig_fields[$past(trigger_select_field)] >> (16 * $past(widx))) == $past(i_avs_writedata[15:0]))
        else $error("load word not stored");
    load_end_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R9
        (mode == PTC_LOAD && cmd_en && !restart) |=> mode == PTC_IDLE)
        else $error("load not ended by enable");
    load_last_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R9
        (load_word_s ##0 (widx == IW'(TRIG_WORDS - 1))) |=> mode == PTC_IDLE)
        else $error("load not ended by last field");
    mode_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R12
        !(restart || cmd_en || load_last) |=> $stable(mode))
        else $error("mode changed without a command");

    // stream words are held against the stores, not against the read mux
    rdback_word_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R7
        ((mode == PTC_READBACK) ##0 stream_read_s) |->
            o_avs_readdata[15:0] == 16'($past(fields[trigger_select_field] >> (16 * widx))))
        else $error("readback word wrong");
    sample_cap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R10
        cmd_smp |=> sample == $past(i_clock_time) && mode == PTC_CLOCK)
        else $error("clock not sampled");
    sample_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R10
        !cmd_smp |=> $stable(sample))
        else $error("time sample changed without a command");
    clock_word_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R10
        ((mode == PTC_CLOCK) ##0 stream_read_s) |->
            o_avs_readdata[15:0] == 16'($past(sample >> (16 * widx))))
        else $error("time word wrong");
    zero_past_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R11
        (rd && sel_tdr && !in_range) |=> o_avs_readdata == 32'h0000_0000)
        else $error("read past end not zero");
    restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R11
        restart |=> widx == '0)
        else $error("word index not restarted");
    seq_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R11
        (tdr_step && !restart && !wdone) |=> widx == $past(widx) + 1'b1)
        else $error("word index did not step");
    step_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R11
        !(tdr_step || restart) |=> $stable(widx))
        else $error("word index moved without an access");
endmodule : ptc_control

/* hw/ptc_pkg.sv */
package ptc_pkg;
    // register word indices (printed offsets are four times these)
    localparam logic [4:0] PTC_IDX_PAGE_SELECT = 5'h13;
    localparam logic [4:0] PTC_IDX_CONTROL = 5'h14;
    localparam logic [4:0] PTC_IDX_TIME_DATA = 5'h15;
    localparam logic [2:0] PTC_PAGE_TIME = 3'h4;
    localparam logic [2:0] PTC_PAGE_RESET = 3'h0;
    // control field positions
    localparam int PTC_SEL_LSB = 10;
    localparam int PTC_BIT_DISABLE = 9;
    localparam int PTC_BIT_ENABLE = 8;
    localparam int PTC_BIT_READBACK = 7;
    localparam int PTC_BIT_LOAD = 6;
    localparam int PTC_BIT_SAMPLE = 5;
    localparam logic [2:0] PTC_SEL_RESET = 3'h0;
    // trigger layout and clock width
    localparam int PTC_NUM_TRIG = 8;
    localparam int PTC_TRIG_WORDS = 4;
    localparam int PTC_TIME_WORDS = 4;
    localparam logic [31:0] PTC_UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {PTC_IDLE, PTC_READBACK, PTC_LOAD, PTC_CLOCK} ptc_mode_e;
endpackage : ptc_pkg

/* hw/ptc_word_seq.sv */
`timescale 1ns/1ps
module ptc_word_seq
#(
    parameter int WORDS = 4
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_restart,
    input wire logic i_step,
    // state
    output logic [$clog2(WORDS+1)-1:0] o_index,
    output logic o_done
);
    logic [$clog2(WORDS+1)-1:0] index;
    localparam logic [$clog2(WORDS+1)-1:0] LAST = ($clog2(WORDS+1))'(WORDS);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn || i_restart)
            index <= '0;
        else if (i_step && index != LAST)
            index <= index + 1'b1;
    end

    assign o_index = index;
    assign o_done = (index == LAST);
endmodule : ptc_word_seq

/* testbench/ptc_control_tb.sv */
`timescale 1ns/1ps
module ptc_control_tb;
    import ptc_pkg::*;
    localparam logic [6:0] A_PG = {PTC_IDX_PAGE_SELECT, 2'b00};
    localparam logic [6:0] A_CT = {PTC_IDX_CONTROL, 2'b00};
    localparam logic [6:0] A_DT = {PTC_IDX_TIME_DATA, 2'b00};
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [6:0] adr = 7'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wreq;
    logic [63:0] ctime = 64'h0;
    logic [7:0] tval = 8'h00;
    logic [7:0] en;
    logic [7:0] pin;
    logic [63:0] flds [8];
    logic [31:0] seed = 32'h068BCF46;
    logic [31:0] q;
    logic [63:0] ef;
    logic [2:0] s;
    int n_errors = 0;
    int compares = 0;
    // byte lanes held full, except for one narrow write that must not reach the command bits
    ptc_control dut
    (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_clock_time(ctime), .i_trig_value(tval), .o_trig_enabled(en), .o_trig_pin(pin), .o_trig_fields(flds)
    );
    initial forever #10 i_sys_clk = ~i_sys_clk;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    // b below zero means no command bit
    function automatic logic [31:0] ctl(input logic [2:0] sl, input int b);
        return ({29'h0, sl} << PTC_SEL_LSB) | ((b >= 0) ? (32'h1 << b) : 32'h0);
    endfunction : ctl
    task final_report();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // waitrequest is judged at the rising edge; read data are taken at the edge where it is low
    task acc(input logic w, input logic [6:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge i_sys_clk);
        while (wreq !== 1'b0)
            @(posedge i_sys_clk);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        // one idle edge keeps the release and the next request out of one time step
        @(posedge i_sys_clk);
    endtask : acc
    task wrt(input logic [6:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wrt
    task rdc(input logic [6:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk({32'h0, q}, {32'h0, e});
    endtask : rdc
    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(posedge i_sys_clk);
        rdc(A_PG, 32'h0);
        wrt(A_CT, ctl(3'h5, -1));
        rdc(A_CT, 32'h0);
        wrt(A_PG, {29'h0, PTC_PAGE_TIME});
        rdc(A_CT, 32'h0);
        rdc(7'h7C, 32'h0);
        wrt(A_CT, 32'hE000 | ctl(3'h5, -1));
        rdc(A_CT, ctl(3'h5, -1));
        be <= 4'h1;
        wrt(A_CT, ctl(3'h2, PTC_BIT_ENABLE));
        be <= 4'hF;
        chk({56'h0, en}, 64'h0);
        rdc(A_CT, ctl(3'h5, -1));
        for (int i = 0; i < 8; i++)
        begin
            s = i[2:0];
            tval <= seed[7:0];
            wrt(A_CT, ctl(s, PTC_BIT_ENABLE));
            chk({63'h0, en[s]}, 64'h1);
            rdc(A_CT, ctl(s, -1));
            wrt(A_CT, ctl(s, PTC_BIT_LOAD));
            chk({63'h0, en[s]}, 64'h0);
            rdc(A_CT, ctl(s, PTC_BIT_LOAD));
            for (int k = 0; k < 4; k++)
            begin
                seed = nxt(seed);
                ef[k*16 +: 16] = seed[15:0];
                wrt(A_DT, seed);
            end
            chk(flds[s], ef);
            rdc(A_CT, ctl(s, -1));
            wrt(A_DT, ~seed);
            chk(flds[s], ef);
            wrt(A_CT, ctl(s, PTC_BIT_READBACK));
            for (int k = 0; k < 4; k++)
                rdc(A_DT, {16'h0, ef[k*16 +: 16]});
            rdc(A_DT, 32'h0);
            wrt(A_CT, ctl(s, PTC_BIT_ENABLE));
            wrt(A_CT, ctl(s, -1));
            chk({63'h0, en[s]}, 64'h1);
            wrt(A_CT, ctl(s, PTC_BIT_DISABLE));
            chk({63'h0, en[s]}, 64'h0);
            rdc(A_CT, ctl(s, -1));
            chk({56'h0, pin}, {56'h0, tval});
        end
        wrt(A_CT, ctl(3'h3, PTC_BIT_LOAD));
        wrt(A_DT, seed);
        wrt(A_CT, ctl(3'h3, PTC_BIT_ENABLE));
        rdc(A_CT, ctl(3'h3, -1));
        chk({63'h0, en[3]}, 64'h1);
        ctime <= {nxt(seed), seed};
        @(posedge i_sys_clk);
        ef = ctime;
        wrt(A_CT, ctl(3'h0, PTC_BIT_SAMPLE));
        ctime <= ~ef;
        rdc(A_CT, ctl(3'h0, -1));
        for (int k = 0; k < 4; k++)
            rdc(A_DT, {16'h0, ef[k*16 +: 16]});
        rdc(A_DT, 32'h0);
        wrt(A_PG, 32'h0);
        rdc(A_DT, 32'h0);
        final_report();
    end
endmodule : ptc_control_tb
